// ==== core/pda_pkg.sv ====
package pda_pkg;
	// ==========================================
	// sizes
	localparam int WORD_W = 6;
	localparam int BANK_W = 4;
	localparam int ADDR_W = 10;
	localparam int DPAGE_W = 1;
	localparam int DWORD_W = 4;
	localparam int DADDR_W = 5;
	localparam int STACK_DEPTH = 2;
	// ==========================================
	// reset values and word increment
	localparam logic [5:0] WORD_RST = 6'h00;
	localparam logic [3:0] BANK_RST = 4'h0;
	localparam logic [3:0] BUF_RST = 4'h0;
	localparam logic [4:0] DADDR_RST = 5'h00;
	localparam logic [5:0] WORD_ONE = 6'h01;
	// ==========================================
	// instruction classes presented by the decoder
	typedef enum logic [4:0]
	{
		OP_SEQ = 5'h01,
		OP_LOAD_BUF = 5'h02,
		OP_JUMP = 5'h04,
		OP_CALL = 5'h08,
		OP_RETURN = 5'h10
	} pda_op_e;
	typedef struct packed
	{
		logic [3:0] bank;
		logic [5:0] word;
	} pda_ret_s;
	typedef struct packed
	{
		logic [3:0] bank_address_bits;
		logic [5:0] word_address_bits;
	} pda_rom_addr_s;
endpackage

// ==== core/pda_addressing.sv ====
// Behaviour
// - program memory of 1024 bytes in 16 pages of 64 words is addressed
// - fetch address is word counter low six bits, page register high four
// - page register is four bits, selecting pages zero to fifteen
// - load-buffer instruction writes the operand into buffer, page unchanged
// - jump or call copies the buffer into the page register
// - page register holds unless a jump, call or return changes it
// - return restores saved page together with saved word address
// - word counter is six bits and increments on each fetch other than a jump, call or return
// - power-up clears word counter and page register to zero
// - return stack holds two entries of word and page
// - call pushes the return word address on the same clock edge that transfers control
// - data memory is 32 nibbles in two pages of sixteen
// - data memory is addressed only through the page and word pointers
// - data page is pointer bit zero, word is four-bit word pointer
// - low reset input sets program address to word zero page zero
module pda_addressing #(
	parameter int DEPTH = pda_pkg::STACK_DEPTH
)
(
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic FETCH,
	input wire pda_pkg::pda_op_e OP,
	input wire logic [5:0] OPERAND,
	input wire logic X_WE,
	input wire logic [1:0] X_IN,
	input wire logic Y_WE,
	input wire logic [3:0] Y_IN,
	output pda_pkg::pda_rom_addr_s ROM_ADDR,
	output logic [3:0] BANK_BUFFER,
	output logic [4:0] RAM_ADDR,
	output logic [1:0] STACK_LEVEL
);
	// ==========================================
	// state
	logic [5:0] word_reg, word_next;
	logic [3:0] bank_reg, bank_next;
	logic [3:0] buf_reg, buf_next;
	logic [1:0] x_reg;
	logic [3:0] y_reg;
	logic [4:0] ram_addr_reg;
	logic [1:0] level_reg, level_next;
	logic sp_reg, sp_next;
	// slot of the most recent push, kept apart from the pointer for empty returns
	logic last_reg, last_next;
	logic [1:0] x_next;
	logic [3:0] y_next;
	pda_pkg::pda_ret_s return_stack [DEPTH];
	pda_pkg::pda_rom_addr_s rom_addr_reg;

	// ==========================================
	// decode
	wire is_load = FETCH && (OP == pda_pkg::OP_LOAD_BUF);
	wire is_jump = FETCH && (OP == pda_pkg::OP_JUMP);
	wire is_call = FETCH && (OP == pda_pkg::OP_CALL);
	wire is_ret = FETCH && (OP == pda_pkg::OP_RETURN);
	wire [5:0] word_inc = word_reg + pda_pkg::WORD_ONE;
	// the return address is the word after the call, on the calling page
	wire pda_pkg::pda_ret_s push_val = '{bank: bank_reg, word: word_inc};
	// popping from an empty stack reuses the last slot written
	wire logic stack_empty = (level_reg == 2'h0);
	wire logic pop_sp = stack_empty ? last_reg : ~sp_reg;
	wire pda_pkg::pda_ret_s pop_val = return_stack[pop_sp];

	// ==========================================
	// helpers
	// saturating live-entry count: the two slots are reused, so the count stops at two
	function automatic logic [1:0] level_step(input logic [1:0] lv, input logic up);
		logic [1:0] res;
		res = lv;
		if (up && (lv != 2'h2))
			res = lv + 2'h1;
		else if (!up && (lv != 2'h0))
			res = lv - 2'h1;
		return res;
	endfunction

	// pointer registers only move on their own write strobes
	always_comb
	begin
		x_next = X_WE ? X_IN : x_reg;
		y_next = Y_WE ? Y_IN : y_reg;
	end

	always_comb
	begin
		word_next = word_reg;
		bank_next = bank_reg;
		buf_next = buf_reg;
		sp_next = sp_reg;
		last_next = last_reg;
		level_next = level_reg;
		if (is_load)
		begin
			buf_next = OPERAND[3:0];
			word_next = word_inc;
		end
		else if (is_jump || is_call)
		begin
			bank_next = buf_reg;
			word_next = OPERAND;
			if (is_call)
			begin
				sp_next = ~sp_reg;
				last_next = sp_reg;
				level_next = level_step(level_reg, 1'b1);
			end
		end
		else if (is_ret)
		begin
			bank_next = pop_val.bank;
			word_next = pop_val.word;
			// an empty return leaves the pointer where it is
			if (!stack_empty)
				sp_next = pop_sp;
			level_next = level_step(level_reg, 1'b0);
		end
		else if (FETCH)
		begin
			word_next = word_inc;
		end
	end

	// ==========================================
	// word counter
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			word_reg <= pda_pkg::WORD_RST;
		end
		else
		begin
			word_reg <= word_next;
		end
	end

	// ==========================================
	// page register
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			bank_reg <= pda_pkg::BANK_RST;
		end
		else
		begin
			bank_reg <= bank_next;
		end
	end

	// ==========================================
	// page buffer
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			buf_reg <= pda_pkg::BUF_RST;
		end
		else
		begin
			buf_reg <= buf_next;
		end
	end

	// ==========================================
	// stack pointer
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			sp_reg <= 1'b0;
		end
		else
		begin
			sp_reg <= sp_next;
		end
	end

	// ==========================================
	// last pushed slot
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			last_reg <= 1'b0;
		end
		else
		begin
			last_reg <= last_next;
		end
	end

	// ==========================================
	// stack level
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			level_reg <= 2'h0;
		end
		else
		begin
			level_reg <= level_next;
		end
	end

	// ==========================================
	// data page pointer
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			x_reg <= 2'h0;
		end
		else
		begin
			x_reg <= x_next;
		end
	end

	// ==========================================
	// data word pointer
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			y_reg <= 4'h0;
		end
		else
		begin
			y_reg <= y_next;
		end
	end

	// stack array has no reset; its content is only read after a write or by an empty return
	always_ff @(posedge SYS_CLK)
	begin
		if (NRST && is_call)
			return_stack[sp_reg] <= push_val;
	end

	// ==========================================
	// fetch address
	// outputs are registered copies so they come straight from flip-flops
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			rom_addr_reg <= '{bank_address_bits: pda_pkg::BANK_RST,
				word_address_bits: pda_pkg::WORD_RST};
		end
		else
		begin
			rom_addr_reg <= '{bank_address_bits: bank_next, word_address_bits: word_next};
		end
	end

	// ==========================================
	// data address
	// only pointer bit zero picks the page; bit one is stored but drives no output
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			ram_addr_reg <= pda_pkg::DADDR_RST;
		end
		else
		begin
			ram_addr_reg <= {x_next[0], y_next};
		end
	end

	assign ROM_ADDR = rom_addr_reg;
	assign BANK_BUFFER = buf_reg;
	assign RAM_ADDR = ram_addr_reg;
	assign STACK_LEVEL = level_reg;
endmodule

// ==== dv/pda_mem_model.sv ====
module pda_mem_model
(
	input wire logic [9:0] rom_addr,
	input wire logic [4:0] ram_addr,
	output logic [7:0] rom_data,
	output logic [3:0] ram_data
);
	timeunit 1ns;
	timeprecision 1ns;
	assign rom_data = rom_addr[7:0];
	assign ram_data = ram_addr[3:0];
endmodule

// ==== dv/pda_addressing_chk.sv ====
module pda_addressing_chk
(
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic FETCH,
	input wire pda_pkg::pda_op_e OP,
	input wire logic [5:0] OPERAND,
	input wire logic X_WE,
	input wire logic [1:0] X_IN,
	input wire logic Y_WE,
	input wire logic [3:0] Y_IN,
	input wire pda_pkg::pda_rom_addr_s ROM_ADDR,
	input wire logic [3:0] BANK_BUFFER,
	input wire logic [4:0] RAM_ADDR,
	input wire logic [1:0] STACK_LEVEL
);
	wire [5:0] w = ROM_ADDR[5:0];
	wire [3:0] b = ROM_ADDR[9:6];
	wire [4:0] t = FETCH ? OP : 5'h00;
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (!NRST);
	sequence s_call_ret;
		t[3] ##1 t[4];
	endsequence
	a_seq_step: assert property (t[0] |=> w == $past(w) + 6'h01 && $stable(b))
		else $error("step");
	a_jump_load: assert property (t[2] | t[3] |=> ROM_ADDR == {$past(BANK_BUFFER), $past(OPERAND)})
		else $error("jump");
	a_buf_load: assert property (t[1] |=> BANK_BUFFER == $past(OPERAND[3:0]) && $stable(b))
		else $error("buffer");
	a_idle_hold: assert property (!t |=> $stable(ROM_ADDR) && $stable(BANK_BUFFER))
		else $error("idle");
	a_call_push: assert property (t[3] && STACK_LEVEL != 2'h2 |=> STACK_LEVEL == $past(STACK_LEVEL) + 2'h1)
		else $error("push");
	a_ret_page: assert property (s_call_ret |=> w == $past(w, 2) + 6'h01 && b == $past(b, 2))
		else $error("return");
	a_ptr_load: assert property (X_WE && Y_WE |=> RAM_ADDR == {$past(X_IN[0]), $past(Y_IN)})
		else $error("pointer");
	a_reset_clear: assert property (disable iff (1'b0) !NRST |=> ROM_ADDR == 10'h000)
		else $error("reset");
endmodule
bind pda_addressing pda_addressing_chk u_chk (.*);

// ==== dv/tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic SYS_CLK = 0, NRST = 0;
	logic [19:0] v = 0;
	logic [20:0] q;
	int failures, compares, w, b, pb, m, lm, p, ev, k, r, s[2], lw, ix, i;
	always #12.5 SYS_CLK = ~SYS_CLK;
	pda_addressing u_dut (.SYS_CLK, .NRST, .FETCH(v[0]), .Y_IN(v[4:1]), .Y_WE(v[5]),
		.X_IN(v[7:6]), .X_WE(v[8]), .OPERAND(v[14:9]), .OP(pda_pkg::pda_op_e'(v[19:15])),
		.ROM_ADDR(q[20:11]), .BANK_BUFFER(q[10:7]), .RAM_ADDR(q[6:2]), .STACK_LEVEL(q[1:0]));
	pda_mem_model u_mem (.rom_addr(q[20:11]), .ram_addr(q[6:2]), .rom_data(), .ram_data());
	task automatic check(input logic [20:0] got, input logic [20:0] exp);
		compares++;
		failures += got !== exp;
		if (got !== exp)
			$display("[ERR] %0t got %h want %h", $time, got, exp);
	endtask
	task automatic tally_and_finish();
		$display("%0d compares %0d failures", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		void'($urandom(32'h75c60f83));
		repeat (4) @(posedge SYS_CLK);
		NRST <= 1'b1;
		for (i = 0; i < 3000; i++)
		begin
			@(posedge SYS_CLK);
			// a second reset in mid-run, seen by the design at the next two edges
			NRST <= !(i == 1500 || i == 1501);
			r = $urandom;
			// no empty return before the stack ever held anything: contents are unknown then
			k = ev || r[4:2] % 5 != 4 ? r[4:2] % 5 : 0;
			v <= {5'h01 << k, r[18:5], r[0] | r[1]};
			@(negedge SYS_CLK);
			check(q, {10'(b * 64 + w), 4'(pb), 5'(m), 2'(lm)});
			m = r[12] ? m % 16 + r[10] * 16 : m;
			m = r[9] ? m / 16 * 16 + r[8:5] : m;
			if (i == 1500 || i == 1501)
			begin
				w = 0; b = 0; pb = 0; m = 0; lm = 0; p = 0; lw = 0;
			end
			else if (r[1:0])
			begin
				w = (w + 1) % 64;
				pb = k == 1 ? r[16:13] : pb;
				if (k == 3)
				begin
					s[p] = b * 64 + w; lw = p; p ^= 1; lm += lm < 2; ev = 1;
				end
				if (k == 4)
				begin
					ix = lm > 0 ? p ^ 1 : lw;
					w = s[ix] % 64; b = s[ix] / 64; p ^= lm > 0; lm -= lm > 0;
				end
				if (k == 2 || k == 3)
				begin
					b = pb; w = r[18:13];
				end
			end
		end
		tally_and_finish();
	end
endmodule
